// ### common/ppp_defs.vh
// Purpose: constants for the parallel printer port
// Assumes: 24-bit system address, 16-bit system data
// Notes: address patterns hold only the decoded bits 23..16
`ifndef PPP_DEFS_VH
`define PPP_DEFS_VH

// ****************************************
// Address decode
// ****************************************
`define PPP_LATCH_MASK 8'hcf
`define PPP_LATCH_MATCH 8'h4f
`define PPP_STAT_MASK 8'hcf
`define PPP_STAT_MATCH 8'h47
`define PPP_MISC_MATCH 8'h4a
`define PPP_CLEAR_MATCH 8'h4c
`define PPP_LATCH_ADDR 24'h4f0000
`define PPP_STAT_ADDR 24'h470000
`define PPP_MISC_ADDR 24'h4a0000
`define PPP_CLEAR_ADDR 24'h4c0000

// ****************************************
// Field positions
// ****************************************
`define PPP_STROBE_BIT 13
`define PPP_ST_BUSY 7
`define PPP_ST_ONLINE 6
`define PPP_ST_PAPER 5
`define PPP_ST_ERROR 4
`define PPP_ST_FLOPPY 3
`define PPP_ST_HDISK 2
`define PPP_ST_PARITY 1
`define PPP_ST_DIAL 0

// ****************************************
// Reset values and timing
// ****************************************
`define PPP_LATCH_RESET 8'h00
`define PPP_CLK_MHZ 20
`define PPP_STROBE_MIN_NS 1000
`define PPP_STROBE_MIN_CYC ((`PPP_STROBE_MIN_NS * `PPP_CLK_MHZ + 999) / 1000)

`endif

// ### src/ppp_sync2.v
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: inputs are slow levels from outside the clock domain
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module ppp_sync2 #(
  parameter W = 8,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ### src/ppp_buf2.v
// Purpose: two-entry buffer for bytes bound for the printer latch
// Assumes: single clock, valid/ready on both sides
// Notes: full and empty are exact; no word lost on a stall
`timescale 1ns/1ps
module ppp_buf2 (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [7:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [7:0] out_data
);
  reg [7:0] mem0;
  reg [7:0] mem1;
  reg rd_ptr;
  reg wr_ptr;
  reg [1:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = rd_ptr ? mem1 : mem0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem0 <= 8'h00;
      mem1 <= 8'h00;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (push) begin
        if (wr_ptr)
          mem1 <= in_data;
        else
          mem0 <= in_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'd1;
      else if (pop && !push)
        count <= count - 2'd1;
    end
  end
endmodule

// ### src/ppp_port.v
// What this block does
// - Data write captures D0-D7 into output latch
// - Decode latch 0,1,x,x,1,1,1,1; status 0,1,x,x,0,1,1,1
// - Status read drives status byte onto bus
// - Latch write completes without wait states
// - Acknowledge trailing edge raises printer interrupt
// - Bit 7 reads one while printer busy
// - Bit 6 reads one while printer online
// - Bit 5 reads one while paper out
// - Bit 4 reads zero on printer error
// - Bit 3 reads floppy interrupt pending
// - Bit 2 reads hard disk interrupt pending
// - Bit 1 sticky zero on parity, cleared by command
// - Bit 0 reads zero on dial tone
// - Status port is read only
// - Single-byte transfers, each strobe, ack, interrupt
//
// Purpose: processor side of the parallel printer port
// Assumes: 20 MHz system clock; bus strobes are one-cycle pulses on clk
// Notes: sel_n strobes are decoded here from bus_addr and registered
`timescale 1ns/1ps
`include "ppp_defs.vh"
module ppp_port (
  input wire clk,
  input wire rst,
  input wire [23:16] bus_addr,
  input wire [15:0] bus_wdata,
  input wire bus_write,
  input wire bus_read,
  output reg [7:0] bus_rdata,
  output reg bus_rdata_oe,
  output reg bus_ready,
  output reg prn_latch_write_sel_n,
  output reg prn_stat_read_sel_n,
  output reg [7:0] prn_out_bits,
  output reg prn_byte_strobe,
  input wire prn_ack_n,
  output reg prn_irq,
  input wire prn_busy_flag,
  input wire prn_online_flag,
  input wire prn_paper_out_flag,
  input wire prn_error_n,
  input wire floppy_irq_flag,
  input wire hard_disk_irq_flag,
  input wire mem_parity_fault_n,
  input wire dial_tone_seen_n,
  output reg clear_status_cmd
);
  // ****************************************
  // Decode helpers
  // ****************************************
  function addr_hit;
    input [7:0] a;
    input [7:0] mask;
    input [7:0] match;
    begin
      addr_hit = ((a & mask) == (match & mask));
    end
  endfunction

  localparam [7:0] MISC_MASK = 8'hff;
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_LOAD = 4'b0010;
  localparam [3:0] ST_STROBE = 4'b0100;
  localparam [3:0] ST_WAIT_ACK = 4'b1000;
  localparam [31:0] STROBE_CYC_FULL = `PPP_STROBE_MIN_CYC;
  localparam [7:0] STROBE_CYC = STROBE_CYC_FULL[7:0];

  wire hit_latch;
  wire hit_stat;
  wire hit_misc;
  wire hit_clear;
  wire latch_wr;
  wire stat_rd;
  wire misc_wr;
  wire clear_wr;

  assign hit_latch = addr_hit(bus_addr, `PPP_LATCH_MASK, `PPP_LATCH_MATCH);
  assign hit_stat = addr_hit(bus_addr, `PPP_STAT_MASK, `PPP_STAT_MATCH);
  assign hit_misc = addr_hit(bus_addr, MISC_MASK, `PPP_MISC_MATCH);
  assign hit_clear = addr_hit(bus_addr, MISC_MASK, `PPP_CLEAR_MATCH);
  assign latch_wr = bus_write && hit_latch;
  assign stat_rd = bus_read && hit_stat;
  assign misc_wr = bus_write && hit_misc;
  // Writes to the status port fall through here and change nothing
  assign clear_wr = bus_write && hit_clear;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [8:0] pins_raw;
  wire [8:0] pins;

  assign pins_raw = {prn_ack_n, prn_busy_flag, prn_online_flag, prn_paper_out_flag,
                     prn_error_n, floppy_irq_flag, hard_disk_irq_flag,
                     mem_parity_fault_n, dial_tone_seen_n};

  // Reset to the idle pin levels: a zero on the active-low pins would
  // set the parity flag and fake an acknowledge edge right after reset
  ppp_sync2 #(.W(9), .INIT(9'h113)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(pins_raw),
    .q(pins)
  );

  wire ack_n_s;
  assign ack_n_s = pins[8];

  // ****************************************
  // Byte buffer in front of the output latch
  // ****************************************
  wire buf_in_ready;
  wire buf_out_valid;
  wire [7:0] buf_out_data;
  reg buf_pop;

  // Latch writes that meet a full buffer are dropped; software must
  // pace bytes by interrupt, one per handshake
  ppp_buf2 u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(latch_wr),
    .in_ready(buf_in_ready),
    .in_data(bus_wdata[7:0]),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );

  // ****************************************
  // Strobe and handshake sequencer
  // ****************************************
  reg [3:0] state;
  reg [3:0] next_state;
  reg [7:0] strobe_cnt;
  reg soft_strobe;
  reg ack_n_d;
  wire ack_rise;

  // Trailing edge of the low acknowledge pulse
  assign ack_rise = ack_n_s && !ack_n_d;

  always @* begin
    next_state = state;
    buf_pop = 1'b0;
    case (state)
      ST_IDLE: begin
        if (buf_out_valid) begin
          buf_pop = 1'b1;
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (soft_strobe)
          next_state = ST_STROBE;
      end
      ST_STROBE: begin
        // Held for the minimum width even if software clears early
        if (!soft_strobe && strobe_cnt >= STROBE_CYC)
          next_state = ST_WAIT_ACK;
      end
      ST_WAIT_ACK: begin
        if (ack_rise)
          next_state = ST_IDLE;
        else if (buf_out_valid && soft_strobe)
          next_state = ST_WAIT_ACK;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      strobe_cnt <= 8'h00;
      soft_strobe <= 1'b0;
      ack_n_d <= 1'b1;
      prn_byte_strobe <= 1'b0;
      prn_irq <= 1'b0;
      prn_out_bits <= `PPP_LATCH_RESET;
    end else begin
      state <= next_state;
      ack_n_d <= ack_n_s;
      if (misc_wr)
        soft_strobe <= bus_wdata[`PPP_STROBE_BIT];
      if (buf_pop)
        prn_out_bits <= buf_out_data;
      if (next_state == ST_STROBE)
        prn_byte_strobe <= 1'b1;
      else
        prn_byte_strobe <= 1'b0;
      if (state == ST_STROBE && strobe_cnt != 8'hff)
        strobe_cnt <= strobe_cnt + 8'h01;
      else if (state != ST_STROBE)
        strobe_cnt <= 8'h00;
      // Acknowledge edge wins over a concurrent strobe clear
      if (ack_rise && state == ST_WAIT_ACK)
        prn_irq <= 1'b1;
      else if (next_state == ST_STROBE && state == ST_LOAD)
        prn_irq <= 1'b0;
    end
  end

  // ****************************************
  // Status port
  // ****************************************
  reg parity_seen;
  wire [7:0] status_byte;

  // Sticky parity flag; a new fault wins over the clear command
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      parity_seen <= 1'b0;
    end else begin
      if (!pins[1])
        parity_seen <= 1'b1;
      else if (clear_wr)
        parity_seen <= 1'b0;
    end
  end

  assign status_byte[`PPP_ST_BUSY] = pins[7];
  assign status_byte[`PPP_ST_ONLINE] = pins[6];
  assign status_byte[`PPP_ST_PAPER] = pins[5];
  assign status_byte[`PPP_ST_ERROR] = pins[4];
  assign status_byte[`PPP_ST_FLOPPY] = pins[3];
  assign status_byte[`PPP_ST_HDISK] = pins[2];
  assign status_byte[`PPP_ST_PARITY] = ~parity_seen;
  assign status_byte[`PPP_ST_DIAL] = pins[0];

  // ****************************************
  // Bus answer
  // ****************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 8'h00;
      bus_rdata_oe <= 1'b0;
      bus_ready <= 1'b0;
      prn_latch_write_sel_n <= 1'b1;
      prn_stat_read_sel_n <= 1'b1;
      clear_status_cmd <= 1'b0;
    end else begin
      bus_rdata <= stat_rd ? status_byte : 8'h00;
      bus_rdata_oe <= stat_rd;
      // Every access answers in one cycle, no wait states
      bus_ready <= bus_write || bus_read;
      prn_latch_write_sel_n <= ~latch_wr;
      prn_stat_read_sel_n <= ~stat_rd;
      clear_status_cmd <= clear_wr;
    end
  end
endmodule

// ### dv/ppp_port_properties.sv
// Purpose: port assertions for ppp_port
// Assumes: one clock, async reset high
// Notes: bound to every ppp_port
`timescale 1ns/1ps
module ppp_port_properties (
  input wire clk,
  input wire rst,
  input wire [23:16] bus_addr,
  input wire bus_write,
  input wire bus_read,
  input wire [7:0] bus_rdata,
  input wire bus_rdata_oe,
  input wire bus_ready,
  input wire prn_latch_write_sel_n,
  input wire prn_stat_read_sel_n,
  input wire [7:0] prn_out_bits,
  input wire prn_byte_strobe,
  input wire prn_ack_n,
  input wire prn_irq,
  input wire clear_status_cmd
);
  reg [15:0] hi_cnt;
  // ****
  // Strobe width counter
  // ****
  always @(posedge clk or posedge rst) begin
    if (rst) hi_cnt <= 16'h0000;
    else if (prn_byte_strobe) hi_cnt <= hi_cnt + 16'h0001;
    else hi_cnt <= 16'h0000;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_ready_after_req: assert property ((bus_write || bus_read) |=> bus_ready)
    else $error("ready missing after request");
  chk_latch_sel: assert property (bus_write && (bus_addr & 8'hcf) == 8'h4f
    |=> !prn_latch_write_sel_n)
    else $error("latch select missing");
  chk_stat_read: assert property (bus_read && (bus_addr & 8'hcf) == 8'h47
    |=> !prn_stat_read_sel_n && bus_rdata_oe)
    else $error("status read not driven");
  chk_rdata_idle: assert property (!bus_rdata_oe |-> bus_rdata == 8'h00)
    else $error("read data not parked");
  chk_strobe_min: assert property ($fell(prn_byte_strobe) |-> hi_cnt >= 16'h0014)
    else $error("strobe too short");
  chk_byte_steady: assert property (prn_byte_strobe |-> $stable(prn_out_bits))
    else $error("byte changed under strobe");
  // Two sync stages plus the prn_irq register put the ack rise 3 to 4 samples back
  chk_irq_cause: assert property ($rose(prn_irq) |-> $past(prn_ack_n, 3) && !$past(prn_ack_n, 4))
    else $error("interrupt without ack end");
  chk_irq_clear: assert property ($rose(prn_byte_strobe) |-> !prn_irq)
    else $error("interrupt not cleared by new strobe");
  chk_clear_cmd: assert property (bus_write && bus_addr == 8'h4c |=> clear_status_cmd)
    else $error("clear command missing");
  cover property ($rose(prn_byte_strobe));
  cover property ($rose(prn_irq));
  cover property (bus_read ##1 bus_rdata_oe);
endmodule
bind ppp_port ppp_port_properties u_chk (.*);

// ### dv/ppp_printer_model.sv
// Purpose: behavioural printer on the strobe/ack link
// Assumes: strobe active high, ack active low
// Notes: ack delay in clocks is set by the bench
`timescale 1ns/1ps
module ppp_printer_model (
  input wire clk,
  input wire [7:0] prn_out_bits,
  input wire prn_byte_strobe,
  input wire [7:0] ack_delay,
  output reg prn_ack_n,
  output reg [7:0] got_byte,
  output reg [7:0] got_count
);
  initial begin
    prn_ack_n = 1'b1;
    got_byte = 8'h00;
    got_count = 8'h00;
  end
  always @(posedge prn_byte_strobe) begin
    got_byte <= prn_out_bits;
    got_count <= got_count + 8'h01;
  end
  // Ack only after the strobe ends, so a short strobe shows up as lost timing
  always @(negedge prn_byte_strobe) begin
    repeat (ack_delay) @(posedge clk);
    #5 prn_ack_n = 1'b0;
    repeat (4) @(posedge clk);
    #5 prn_ack_n = 1'b1;
  end
endmodule

// ### dv/test_parallel_printer_port.sv
// Purpose: self-checking bench for ppp_port
// Assumes: inputs change 5 ns after the rising edge
// Notes: status pins are driven from one byte in status order
`timescale 1ns/1ps
module test_parallel_printer_port;
  reg clk = 1'b0, rst = 1'b1, bus_write = 1'b0, bus_read = 1'b0;
  reg [7:0] bus_addr = 8'h00, st = 8'hff, ack_delay = 8'h02, r, v;
  reg [15:0] bus_wdata = 16'h0000;
  wire [7:0] bus_rdata, prn_out_bits, got_byte, got_count;
  wire bus_rdata_oe, bus_ready, prn_latch_write_sel_n, prn_stat_read_sel_n;
  wire prn_byte_strobe, prn_ack_n, prn_irq, clear_status_cmd;
  integer fails = 0, checked = 0, cyc = 0, i, n;
  always #25 clk = ~clk;
  ppp_port u_dut (.*, .prn_busy_flag(st[7]), .prn_online_flag(st[6]),
    .prn_paper_out_flag(st[5]), .prn_error_n(st[4]), .floppy_irq_flag(st[3]),
    .hard_disk_irq_flag(st[2]), .mem_parity_fault_n(st[1]), .dial_tone_seen_n(st[0]));
  ppp_printer_model u_prn (.*);
  // ****
  // Tasks
  // ****
  task print_verdict;
    begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask
  task chk8(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer k);
    begin
      repeat (k) @(posedge clk);
      #5;
    end
  endtask
  task bus(input w, input [7:0] a, input [15:0] d);
    begin
      tick(1);
      bus_write = w;
      bus_read = !w;
      bus_addr = a;
      bus_wdata = d;
      tick(1);
      bus_write = 1'b0;
      bus_read = 1'b0;
      r = bus_rdata;
      chk8({7'h00, bus_ready}, 8'h01);
      if (!w) chk8({7'h00, bus_rdata_oe}, {7'h00, (a & 8'hcf) == 8'h47});
      chk8({6'h00, prn_latch_write_sel_n, prn_stat_read_sel_n},
           {6'h00, !(w && (a & 8'hcf) == 8'h4f), !(!w && (a & 8'hcf) == 8'h47)});
      chk8({7'h00, clear_status_cmd}, {7'h00, w && a == 8'h4c});
    end
  endtask
  // Software clears the strobe bit at once; the port must stretch it
  task job(input [7:0] b);
    begin
      tick(2);
      chk8(prn_out_bits, b);
      bus(1'b1, 8'h4a, 16'h2000);
      tick(1);
      chk8({6'h00, prn_byte_strobe, prn_irq}, 8'h02);
      bus(1'b1, 8'h4a, 16'h0000);
      n = 0;
      while (prn_irq !== 1'b1 && n < 400) begin
        tick(1);
        n = n + 1;
      end
      chk8({7'h00, prn_irq}, 8'h01);
      chk8(got_byte, b);
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      print_verdict;
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    tick(12);
    rst = 1'b0;
    chk8({prn_out_bits[5:0], prn_byte_strobe, prn_irq}, 8'h00);
    $display("test reset done");
    for (i = 0; i < 8; i = i + 1) begin
      st = 8'h02 | (8'h01 << i);
      tick(3);
      bus(1'b0, i[0] ? 8'h77 : 8'h47, 16'h0000);
      chk8(r, st);
      st = ~(8'h01 << i) | 8'h02;
      tick(3);
      bus(1'b0, 8'h47, 16'h0000);
      chk8(r, st);
    end
    st = 8'hfd;
    tick(3);
    st = 8'hff;
    tick(3);
    bus(1'b0, 8'h47, 16'h0000);
    chk8(r, 8'hfd);
    bus(1'b1, 8'h47, 16'h00ff);
    bus(1'b0, 8'h47, 16'h0000);
    chk8(r, 8'hfd);
    bus(1'b1, 8'h4c, 16'h0000);
    tick(3);
    bus(1'b0, 8'h47, 16'h0000);
    chk8(r, 8'hff);
    bus(1'b0, 8'h12, 16'h0000);
    chk8(r, 8'h00);
    $display("test status done");
    bus(1'b1, 8'h4f, 16'hff55);
    job(8'h55);
    ack_delay = 8'h3c;
    bus(1'b1, 8'h7f, 16'h00aa);
    job(8'haa);
    v = 8'h00;
    for (i = 0; i < 4; i = i + 1) begin
      v = v + 8'h11;
      bus(1'b1, 8'h4f, {8'h00, v});
    end
    job(8'h11);
    job(8'h22);
    job(8'h33);
    tick(4);
    chk8(prn_out_bits, 8'h33);
    chk8(got_count, 8'h05);
    $display("test print done");
    print_verdict;
  end
endmodule
